// [inc/eldl_pkg.sv]
package eldl_pkg;

  // Data path shape
  localparam int DATA_W = 8;
  localparam int NTAPS = 4;
  localparam int TAPS_W = 32;
  localparam int BUF_DEPTH = 2;
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;

  // Register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] HEAD_OFS = 8'h08;

  // Control fields and reset value
  localparam int CTRL_REV_BIT = 0;
  localparam int CTRL_RUN_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h2;

  // Status fields
  localparam int ST_RP_BIT = 0;
  localparam int ST_SP_BIT = 1;
  localparam int ST_RDY_BIT = 2;
  localparam int ST_VLD_BIT = 3;
  localparam int ST_LVL_LSB = 4;
  localparam int ST_LVL_W = 3;

  // Output buffer fill level
  typedef enum logic [2:0] {
    LVL_EMPTY = 3'b001,
    LVL_ONE = 3'b010,
    LVL_FULL = 3'b100
  } eldl_level_type;

endpackage

// [hw/eldl_hold_stage.sv]
`timescale 1ns/100ps

module eldl_hold_stage
  import eldl_pkg::*;
#(
  parameter int W = DATA_W,
  parameter bit ZERO_LAT = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] held;
  } eldl_stage_state_type;

  eldl_stage_state_type st_q;
  eldl_stage_state_type st_d;

  // Both variants store alike; only the output tap differs
  always_comb begin
    st_d = st_q;
    if (en_i) begin
      st_d.held = d_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  generate
    if (ZERO_LAT) begin : g_zero
      // Combinational path from d_i; callers must not loop it back
      assign q_o = en_i ? d_i : st_q.held;

      property p_zero_pass;
        @(posedge clk_i) disable iff (!rst_n_i)
        en_i |-> (q_o == d_i);
      endproperty
      a_zero_pass: assert property (p_zero_pass)
        else $error("zero delay stage does not pass data");

      property p_zero_fall;
        @(posedge clk_i) disable iff (!rst_n_i)
        (!en_i && $past(en_i)) |-> (q_o == $past(d_i));
      endproperty
      a_zero_fall: assert property (p_zero_fall)
        else $error("zero delay stage lost previous data");
    end else begin : g_one
      assign q_o = st_q.held;

      property p_one_delay;
        @(posedge clk_i) disable iff (!rst_n_i)
        en_i |=> (q_o == $past(d_i));
      endproperty
      a_one_delay: assert property (p_one_delay)
        else $error("one cycle stage output not delayed input");

      property p_one_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        !en_i |=> $stable(q_o);
      endproperty
      a_one_hold: assert property (p_one_hold)
        else $error("one cycle stage changed while disabled");
    end
  endgenerate

endmodule

// [hw/eldl_top.sv]
// Function
// - Both latches update one cycle after inputs.
// - Set and reset low keeps latch value.
// - Reset-priority latch: both high gives zero.
// - Set-priority latch: both high gives one.
// - Hold enable is one bit, high passes.
// - One-cycle stage delays when enabled, else holds.
// - One-cycle stage enable acts next cycle.
// - Hold stages work for any data width.
// - Zero-delay stage passes data same cycle.
// - Zero-delay stage holds previous input when disabled.
// - Zero-delay stage enable acts immediately.
// - Tap chain: scalar in, tap vector, valid. Here data_i is DATA_W (8) bits wide.
// - First stage selectable, then one-cycle stages.
// - Least delayed tap first unless reversed.
// - Tap chain input must be scalar. Here data_i takes DATA_W-bit (8-bit) words.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps

module eldl_top
  import eldl_pkg::*;
#(
  parameter bit FIRST_ZERO = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [APB_AW-1:0] paddr_i,
  input wire logic [APB_DW-1:0] pwdata_i,
  output logic [APB_DW-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic set_i,
  input wire logic clr_i,
  output logic rp_latch_o,
  output logic sp_latch_o,
  input wire logic [DATA_W-1:0] data_i,
  input wire logic data_en_i,
  output logic in_ready_o,
  output logic [TAPS_W-1:0] taps_o,
  output logic tap_valid_o,
  input wire logic out_ready_i
);

  localparam int VLD_LAT = FIRST_ZERO ? 0 : 1;

  typedef struct packed {
    logic rp;
    logic sp;
    logic rev;
    logic run;
    logic en;
    eldl_level_type lvl;
    logic vld;
    logic rdy;
    logic [TAPS_W-1:0] ent0;
    logic [TAPS_W-1:0] ent1;
    logic [APB_DW-1:0] rdata;
    logic pready;
    logic pslverr;
  } eldl_top_state_type;

  localparam eldl_top_state_type ST_RST = '{
    lvl: LVL_EMPTY,
    rdy: 1'b1,
    rev: CTRL_RST[CTRL_REV_BIT],
    run: CTRL_RST[CTRL_RUN_BIT],
    default: '0
  };

  eldl_top_state_type q;
  eldl_top_state_type d;

  logic chain_en;
  logic chain_valid;
  logic [TAPS_W-1:0] taps_raw;
  logic [TAPS_W-1:0] taps_ord;
  logic push;
  logic pop;
  logic setup_ph;
  logic wr_take;

  function automatic logic reg_known(input logic [APB_AW-1:0] a);
    reg_known = (a == CTRL_OFS) || (a == STATUS_OFS) ||
                (a == HEAD_OFS);
  endfunction

  function automatic logic [TAPS_W-1:0] reverse_taps(
    input logic [TAPS_W-1:0] t
  );
    logic [TAPS_W-1:0] r;
    r = '0;
    for (int k = 0; k < NTAPS; k++) begin
      r[k*DATA_W +: DATA_W] = t[(NTAPS-1-k)*DATA_W +: DATA_W];
    end
    reverse_taps = r;
  endfunction

  // Stalls the chain when the output buffer cannot take a word
  assign chain_en = data_en_i & q.run & q.rdy;
  assign chain_valid = FIRST_ZERO ? chain_en : q.en;

  // Tap chain: first stage picked by parameter, rest one-cycle
  generate
    for (genvar k = 0; k < NTAPS; k++) begin : g_stage
      if (k == 0) begin : g_first
        eldl_hold_stage #(
          .W(DATA_W),
          .ZERO_LAT(FIRST_ZERO)
        ) u_stage (
          .clk_i(clk_i),
          .rst_n_i(rst_n_i),
          .en_i(chain_en),
          .d_i(data_i),
          .q_o(taps_raw[DATA_W-1:0])
        );
      end else begin : g_next
        eldl_hold_stage #(
          .W(DATA_W),
          .ZERO_LAT(1'b0)
        ) u_stage (
          .clk_i(clk_i),
          .rst_n_i(rst_n_i),
          .en_i(chain_en),
          .d_i(taps_raw[(k-1)*DATA_W +: DATA_W]),
          .q_o(taps_raw[k*DATA_W +: DATA_W])
        );
      end
    end
  endgenerate

  assign taps_ord = q.rev ? reverse_taps(taps_raw) : taps_raw;
  assign push = chain_valid;
  assign pop = q.vld & out_ready_i;
  assign setup_ph = psel_i & ~penable_i;
  assign wr_take = psel_i & penable_i & pwrite_i & q.pready;

  always_comb begin
    d = q;

    // Reset-priority latch
    if (clr_i) begin
      d.rp = 1'b0;
    end else if (set_i) begin
      d.rp = 1'b1;
    end else begin
      d.rp = q.rp;
    end

    // Set-priority latch
    if (set_i) begin
      d.sp = 1'b1;
    end else if (clr_i) begin
      d.sp = 1'b0;
    end else begin
      d.sp = q.sp;
    end

    d.en = chain_en;

    // Two-entry output buffer, head always in ent0
    case (q.lvl)
      LVL_EMPTY: begin
        if (push) begin
          d.ent0 = taps_ord;
          d.lvl = LVL_ONE;
        end
      end
      LVL_ONE: begin
        if (push && pop) begin
          d.ent0 = taps_ord;
        end else if (push) begin
          d.ent1 = taps_ord;
          d.lvl = LVL_FULL;
        end else if (pop) begin
          d.lvl = LVL_EMPTY;
        end
      end
      LVL_FULL: begin
        if (pop) begin
          d.ent0 = q.ent1;
          if (push) begin
            d.ent1 = taps_ord;
          end else begin
            d.lvl = LVL_ONE;
          end
        end
      end
      default: begin
        d.lvl = LVL_EMPTY;
      end
    endcase
    d.vld = (d.lvl != LVL_EMPTY);
    // A word still in flight in the first stage reserves a slot
    d.rdy = (d.lvl == LVL_EMPTY) ||
            ((d.lvl == LVL_ONE) && !(d.en && !FIRST_ZERO));

    // APB: answer in the first access cycle, no wait states
    d.pready = setup_ph;
    d.pslverr = 1'b0;
    d.rdata = '0;
    if (setup_ph) begin
      d.pslverr = ~reg_known(paddr_i);
      if (!pwrite_i) begin
        case (paddr_i)
          CTRL_OFS: begin
            d.rdata[CTRL_REV_BIT] = q.rev;
            d.rdata[CTRL_RUN_BIT] = q.run;
          end
          STATUS_OFS: begin
            d.rdata[ST_RP_BIT] = q.rp;
            d.rdata[ST_SP_BIT] = q.sp;
            d.rdata[ST_RDY_BIT] = q.rdy;
            d.rdata[ST_VLD_BIT] = q.vld;
            d.rdata[ST_LVL_LSB +: ST_LVL_W] = q.lvl;
          end
          HEAD_OFS: begin
            d.rdata = q.ent0;
          end
          default: begin
            d.rdata = '0;
          end
        endcase
      end
    end
    if (wr_take && (paddr_i == CTRL_OFS)) begin
      d.rev = pwdata_i[CTRL_REV_BIT];
      d.run = pwdata_i[CTRL_RUN_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  assign prdata_o = q.rdata;
  assign pready_o = q.pready;
  assign pslverr_o = q.pslverr;
  assign rp_latch_o = q.rp;
  assign sp_latch_o = q.sp;
  assign in_ready_o = q.rdy;
  assign taps_o = q.ent0;
  assign tap_valid_o = q.vld;

  default clocking cb_main @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_rp_both;
    (set_i && clr_i) |=> !rp_latch_o;
  endproperty
  a_rp_both: assert property (p_rp_both)
    else $error("reset priority latch set when both high");

  property p_sp_both;
    (set_i && clr_i) |=> sp_latch_o;
  endproperty
  a_sp_both: assert property (p_sp_both)
    else $error("set priority latch clear when both high");

  property p_latch_keep;
    (!set_i && !clr_i) |=> ($stable(rp_latch_o) && $stable(sp_latch_o));
  endproperty
  a_latch_keep: assert property (p_latch_keep)
    else $error("latch changed with set and reset low");

  sequence s_set_only;
    set_i && !clr_i;
  endsequence

  sequence s_clr_only;
    clr_i && !set_i;
  endsequence

  property p_latch_set;
    s_set_only |=> (rp_latch_o && sp_latch_o);
  endproperty
  a_latch_set: assert property (p_latch_set)
    else $error("latch not set one cycle after set");

  property p_latch_clr;
    s_clr_only |=> (!rp_latch_o && !sp_latch_o);
  endproperty
  a_latch_clr: assert property (p_latch_clr)
    else $error("latch not cleared one cycle after reset");

  property p_valid_lat;
    chain_en |-> ##VLD_LAT chain_valid;
  endproperty
  a_valid_lat: assert property (p_valid_lat)
    else $error("tap valid latency differs from first stage");

  property p_valid_idle;
    !chain_en |-> ##VLD_LAT !chain_valid;
  endproperty
  a_valid_idle: assert property (p_valid_idle)
    else $error("tap valid without enable");

  property p_tap_shift;
    chain_en |=>
      (taps_raw[2*DATA_W-1:DATA_W] == $past(taps_raw[DATA_W-1:0]));
  endproperty
  a_tap_shift: assert property (p_tap_shift)
    else $error("second tap is not shifted first tap");

  property p_tap_still;
    !chain_en |=> $stable(taps_raw[TAPS_W-1:DATA_W]);
  endproperty
  a_tap_still: assert property (p_tap_still)
    else $error("later taps moved while chain disabled");

  property p_order;
    q.rev ?
      (taps_ord[DATA_W-1:0] == taps_raw[TAPS_W-1 -: DATA_W]) :
      (taps_ord[DATA_W-1:0] == taps_raw[DATA_W-1:0]);
  endproperty
  a_order: assert property (p_order)
    else $error("tap vector order wrong");

  property p_reset_clear;
    $rose(rst_n_i) |-> (!rp_latch_o && !sp_latch_o && !tap_valid_o &&
                        (taps_raw == '0));
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("state not cleared by reset");

  sequence s_full_stall;
    (q.lvl == LVL_FULL) && !out_ready_i;
  endsequence

  property p_no_overflow;
    s_full_stall |-> !push;
  endproperty
  a_no_overflow: assert property (p_no_overflow)
    else $error("word pushed into full buffer");

  property p_head_stall;
    (tap_valid_o && !out_ready_i) |=> (tap_valid_o && $stable(taps_o));
  endproperty
  a_head_stall: assert property (p_head_stall)
    else $error("buffer head changed while stalled");

  sequence s_ctrl_write;
    (psel_i && !penable_i && pwrite_i && (paddr_i == CTRL_OFS))
    ##1 (psel_i && penable_i);
  endsequence

  property p_ctrl_write;
    s_ctrl_write |=> (q.run == $past(pwdata_i[CTRL_RUN_BIT]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control write not applied");

  property p_apb_ready;
    (psel_i && !penable_i) |=> pready_o;
  endproperty
  a_apb_ready: assert property (p_apb_ready)
    else $error("no answer in first access cycle");

endmodule

// [tb/eldl_sink.sv]
`timescale 1ns/100ps

module eldl_sink (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  output logic ready_o
);
  initial ready_o = 1'b0;
  // Slow mode stalls most cycles so the buffer backs up
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      ready_o <= 1'b0;
    end else if (slow_i) begin
      ready_o <= ($urandom % 5) == 0;
    end else begin
      ready_o <= ($urandom % 4) != 0;
    end
  end
endmodule

// [tb/testbench.sv]
`timescale 1ns/100ps

module testbench;
  import eldl_pkg::*;
  logic clk_i, rst_n_i, psel, pen, pwr, set, clr, en, slow, go, run, rev;
  logic pready, pslverr, rp, sp, in_rdy, tv, ordy, er, erp, esp, stall;
  logic rp_z, sp_z, in_rdy_z, tv_z;
  logic [7:0] paddr, din;
  logic [31:0] pwdata, prdata, taps, rd, taps_z, hist, hist_z;
  logic [31:0] expq [$];
  logic [31:0] expz [$];
  int n_fail, samples_checked;

  eldl_top uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .set_i(set), .clr_i(clr), .rp_latch_o(rp), .sp_latch_o(sp),
    .data_i(din), .data_en_i(en), .in_ready_o(in_rdy), .taps_o(taps),
    .tap_valid_o(tv), .out_ready_i(ordy));
  // Second copy exercises the zero-delay first stage
  eldl_top #(.FIRST_ZERO(1'b1)) uut_zero (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(), .pready_o(), .pslverr_o(),
    .set_i(set), .clr_i(clr), .rp_latch_o(rp_z), .sp_latch_o(sp_z),
    .data_i(din), .data_en_i(en), .in_ready_o(in_rdy_z), .taps_o(taps_z),
    .tap_valid_o(tv_z), .out_ready_i(ordy));
  eldl_sink partner (.clk_i(clk_i), .rst_n_i(rst_n_i), .slow_i(slow),
    .ready_o(ordy));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task chk(input string nm, input logic [31:0] got, input logic [31:0] ex);
    samples_checked++;
    if (got !== ex) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 50) begin
      n_fail++;
      give_verdict;
    end
  endtask

  // Expected vector; tap 0 is the newest word unless reversed
  function logic [31:0] vec(input logic r, input logic [31:0] h);
    vec = r ? {h[7:0], h[15:8], h[23:16], h[31:24]} : h;
  endfunction

  task stream(input int cycles);
    int n;
    go <= 1'b1;
    slow <= 1'b1;
    repeat (cycles / 2) @(posedge clk_i);
    slow <= 1'b0;
    repeat (cycles / 2) @(posedge clk_i);
    go <= 1'b0;
    repeat (3) @(posedge clk_i);
    n = 0;
    while ((expq.size() != 0 || expz.size() != 0) && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    @(posedge clk_i);
    #1;
    chk("queue left", expq.size(), 0);
    chk("valid idle", tv, 1'b0);
    chk("queue left zero", expz.size(), 0);
    chk("valid idle zero", tv_z, 1'b0);
  endtask

  always @(posedge clk_i) begin
    en <= go & (($urandom % 3) != 0);
    din <= 8'($urandom);
  end

  // Model of both chains; words accepted only while ready and running
  always @(posedge clk_i) begin
    if (rst_n_i && en && in_rdy && run) begin
      hist = {hist[23:0], din};
      expq.push_back(vec(rev, hist));
    end
    if (rst_n_i && en && in_rdy_z && run) begin
      hist_z = {hist_z[23:0], din};
      expz.push_back(vec(rev, hist_z));
    end
    if (!in_rdy) stall = 1'b1;
    if (rst_n_i && tv && ordy) begin
      if (expq.size() == 0) chk("extra pop", 1'b1, 1'b0);
      else chk("taps", taps, expq.pop_front());
    end
    if (rst_n_i && tv_z && ordy) begin
      if (expz.size() == 0) chk("extra pop zero", 1'b1, 1'b0);
      else chk("taps zero", taps_z, expz.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    give_verdict;
  end

  initial begin
    {psel, pen, pwr, set, clr, en, slow, go, erp, esp, stall} = '0;
    paddr = '0;
    pwdata = '0;
    din = '0;
    run = 1'b1;
    rev = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    hist = '0;
    hist_z = '0;
    rst_n_i = 1'b0;
    void'($urandom(99));
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
    chk("taps", taps, 32'h0);
    chk("outs", {tv, rp, sp, in_rdy}, 32'h1);
    chk("taps zero", taps_z, 32'h0);
    chk("outs zero", {tv_z, rp_z, sp_z, in_rdy_z}, 32'h1);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl", rd, 32'h2);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status", rd, 32'h14);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped", {er, rd[30:0]}, 32'h80000000);
    $display("test reset done");
    repeat (24) begin
      @(posedge clk_i);
      set <= 1'($urandom);
      clr <= 1'($urandom);
      @(posedge clk_i);
      #1;
      erp = clr ? 1'b0 : (set ? 1'b1 : erp);
      esp = set ? 1'b1 : (clr ? 1'b0 : esp);
      chk("rp latch", rp, erp);
      chk("sp latch", sp, esp);
      chk("rp latch zero", rp_z, erp);
      chk("sp latch zero", sp_z, esp);
    end
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status latches", rd[1:0], {esp, erp});
    $display("test latch done");
    stream(400);
    chk("stall seen", stall, 1'b1);
    $display("test stream done");
    apb(1'b1, CTRL_OFS, 32'h3);
    rev = 1'b1;
    stream(200);
    $display("test reverse done");
    apb(1'b1, CTRL_OFS, 32'h0);
    run = 1'b0;
    rev = 1'b0;
    stream(60);
    $display("test halt done");
    // Reset after the halt test with latches set and taps loaded
    set <= 1'b1;
    clr <= 1'b0;
    @(posedge clk_i);
    set <= 1'b0;
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
    chk("taps", taps, 32'h0);
    chk("outs", {tv, rp, sp, in_rdy}, 32'h1);
    chk("taps zero", taps_z, 32'h0);
    chk("outs zero", {tv_z, rp_z, sp_z, in_rdy_z}, 32'h1);
    hist = '0;
    hist_z = '0;
    run = 1'b1;
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl", rd, 32'h2);
    // Chain must restart from cleared stages
    stream(60);
    $display("test restart done");
    give_verdict;
  end
endmodule
